// [hw/optical_module_mgmt.sv]
// Management pins, reset sequencing and two-wire memory map access of the module.
// Notes on behaviour
// - Serial bus served only while select low.
// - Long reset pulse restores all defaults.
// - Completion shown by attention with not-ready clear.
// - Power-up posts completion without reset pulse.
// - Attention low on fault or critical status.
// - Attention is open-drain, never driven high.
// - Presence line held low while inserted.
// - Transmitter off by pin or serial bit.
// - Signal-lost alarm when any lane weak.
// - Lane received levels readable over serial bus.
// - Low-power pin sets power limit.
// - Module serves two-wire clock/data memory access.
// - Fully functional within 2000 ms of power.
`timescale 1ns/1ps
module optical_module_mgmt #(
  parameter int unsigned INIT_CYCLES = optical_mgmt_pkg::INIT_CYCLES,
  parameter int unsigned RESET_MIN_CYCLES = optical_mgmt_pkg::RESET_MIN_CYCLES
) (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Host control pins.
  input wire logic i_module_select_n,
  input wire logic i_module_reset_n,
  input wire logic i_low_power_pin,
  input wire logic i_transmit_disable,
  // Two-wire serial bus.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Open-drain status pins and the driven signal-lost output.
  output logic o_attention_n_o,
  output logic o_attention_n_oe,
  output logic o_presence_n_o,
  output logic o_presence_n_oe,
  output logic o_receive_signal_lost,
  // Module internals.
  input wire logic [optical_mgmt_pkg::LANES-1:0] i_lane_signal_low,
  input wire logic [31:0] i_optical_monitor,
  input wire logic i_fault,
  output logic [optical_mgmt_pkg::LANES-1:0] o_tx_off,
  output logic o_high_power_en,
  output logic o_data_not_ready
);
  import optical_mgmt_pkg::*;

  mgmt_state_t s_r;
  mgmt_state_t s_nxt;
  mmap_if m ();

  // All checks in this module run on the management clock and pause during reset.
  default clocking mgmt_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  logic [PIN_W-1:0] filt_new;
  logic scl_rise, scl_fall, start_c, stop_c, load;
  logic [7:0] byte_in;
  logic [FLAG_W-1:0] set_f, clr_f;

  mmap_regs u_regs (.i_mclk(i_mclk), .i_rst(i_rst), .m(m));

  always_comb begin
    s_nxt = s_r;
    load = 1'b0;
    clr_f = '0;
    set_f = '0;
    s_nxt.wr_en = 1'b0;
    s_nxt.sync1 = {i_lane_signal_low, i_transmit_disable, i_low_power_pin,
                   i_module_reset_n, i_module_select_n, i_sda, i_scl};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    filt_new = (s_r.sync2 & s_r.sync3) | (s_r.filt & (s_r.sync2 | s_r.sync3));
    s_nxt.filt = filt_new;
    scl_rise = !s_r.filt[P_SCL] && filt_new[P_SCL];
    scl_fall = s_r.filt[P_SCL] && !filt_new[P_SCL];
    start_c = s_r.filt[P_SCL] && filt_new[P_SCL] && s_r.filt[P_SDA] && !filt_new[P_SDA];
    stop_c = s_r.filt[P_SCL] && filt_new[P_SCL] && !s_r.filt[P_SDA] && filt_new[P_SDA];
    byte_in = {s_r.shreg[6:0], filt_new[P_SDA]};

    // Reset pin qualification and initialisation sequence.
    if (!s_r.filt[P_RST]) begin
      if (s_r.rst_cnt != RST_CNT_W'(RESET_MIN_CYCLES)) begin
        s_nxt.rst_cnt = s_r.rst_cnt + 1'b1;
      end else begin
        s_nxt.mode = MODE_HELD;
      end
    end else begin
      s_nxt.rst_cnt = '0;
      if (s_r.mode == MODE_HELD) begin
        s_nxt.mode = MODE_INIT;
        s_nxt.init_cnt = '0;
      end
    end
    if (s_r.mode == MODE_INIT && s_nxt.mode != MODE_HELD) begin
      s_nxt.init_cnt = s_r.init_cnt + 1'b1;
      if (s_r.init_cnt == INIT_CNT_W'(INIT_CYCLES - 1)) begin
        s_nxt.mode = MODE_RUN;
        set_f[F_DONE] = 1'b1;
      end
    end

    // Two-wire slave.
    if (s_r.filt[P_SEL]) begin
      s_nxt.ser = SER_IDLE;
      s_nxt.drive = 1'b0;
    end else if (start_c) begin
      s_nxt.ser = SER_DEVADDR;
      s_nxt.bit_cnt = '0;
      s_nxt.drive = 1'b0;
    end else if (stop_c) begin
      s_nxt.ser = SER_IDLE;
      s_nxt.drive = 1'b0;
    end else begin
      case (s_r.ser)
        SER_DEVADDR, SER_OFFSET, SER_WRITE: begin
          if (scl_rise) begin
            s_nxt.shreg = byte_in;
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
            if (s_r.bit_cnt == 4'h7) begin
              s_nxt.bit_cnt = '0;
              s_nxt.ser = SER_ACK;
              if (s_r.ser == SER_DEVADDR) begin
                if (byte_in[7:1] != DEV_ADDR) begin
                  s_nxt.ser = SER_IDLE;
                end
                s_nxt.ser_next = byte_in[0] ? SER_READ : SER_OFFSET;
              end else if (s_r.ser == SER_OFFSET) begin
                s_nxt.offset = byte_in;
                s_nxt.ser_next = SER_WRITE;
              end else begin
                s_nxt.wr_en = 1'b1;
                s_nxt.wr_addr = s_r.offset;
                s_nxt.wdata = byte_in;
                s_nxt.offset = s_r.offset + 1'b1;
                s_nxt.ser_next = SER_WRITE;
              end
            end
          end
        end
        SER_ACK: begin
          if (scl_fall) begin
            s_nxt.drive = !s_r.drive;
            if (s_r.drive) begin
              s_nxt.ser = s_r.ser_next;
              load = (s_r.ser_next == SER_READ);
            end
          end
        end
        SER_READ: begin
          if (scl_fall) begin
            if (s_r.bit_cnt == 4'h8) begin
              s_nxt.drive = 1'b0;
              s_nxt.ser = SER_RACK;
            end else begin
              s_nxt.drive = !s_r.shreg[7];
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
            end
          end
        end
        SER_RACK: begin
          if (scl_rise) begin
            s_nxt.nack = filt_new[P_SDA];
          end else if (scl_fall) begin
            if (s_r.nack) begin
              s_nxt.ser = SER_IDLE;
            end else begin
              s_nxt.ser = SER_READ;
              load = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.ser = SER_IDLE;
        end
      endcase
    end
    if (load) begin
      s_nxt.drive = !m.rdata[7];
      s_nxt.shreg = {m.rdata[6:0], 1'b0};
      s_nxt.bit_cnt = 4'h1;
      s_nxt.offset = s_r.offset + 1'b1;
      if (s_r.offset == OFF_FLAGS) begin
        clr_f = m.rdata[FLAG_W-1:0];
      end
    end

    // Sticky flags: a new event wins over the clear by a read.
    set_f[F_FAULT] = set_f[F_FAULT] | i_fault;
    set_f[F_LOS +: LANES] = filt_new[P_LOS +: LANES] & ~s_r.filt[P_LOS +: LANES];
    s_nxt.flags = (s_r.flags & ~clr_f) | set_f;
    if (s_r.mode == MODE_HELD) begin
      s_nxt.flags = '0;
    end

    s_nxt.lost = |s_r.filt[P_LOS +: LANES];
    s_nxt.tx_off = {LANES{s_r.filt[P_TXD]}} | m.tx_soft |
                   {LANES{s_r.mode != MODE_RUN}};
    s_nxt.high_power = !s_r.filt[P_LP] && s_r.mode == MODE_RUN;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.sync1 <= PIN_RESET;
      s_r.sync2 <= PIN_RESET;
      s_r.sync3 <= PIN_RESET;
      s_r.filt <= PIN_RESET;
      s_r.tx_off <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.wr_en = s_r.wr_en;
  assign m.wr_addr = s_r.wr_addr;
  assign m.wdata = s_r.wdata;
  assign m.rd_addr = s_r.offset;
  assign m.soft_rst = (s_r.mode == MODE_HELD);
  assign m.status = {7'h00, s_r.mode != MODE_RUN};
  assign m.flags = {2'h0, s_r.flags};
  assign m.monitor = i_optical_monitor;
  assign m.los = s_r.filt[P_LOS +: LANES];

  assign o_sda_o = 1'b0;
  assign o_sda_oe = s_r.drive;
  assign o_attention_n_o = 1'b0;
  assign o_attention_n_oe = |s_r.flags;
  assign o_presence_n_o = 1'b0;
  assign o_presence_n_oe = 1'b1;
  assign o_receive_signal_lost = s_r.lost;
  assign o_tx_off = s_r.tx_off;
  assign o_high_power_en = s_r.high_power;
  assign o_data_not_ready = (s_r.mode != MODE_RUN);

  property p_sel_ignore;
    s_r.filt[P_SEL] |=> (s_r.ser == SER_IDLE && !o_sda_oe);
  endproperty
  a_sel_ignore: assert property (p_sel_ignore) else $error("bus served while deselected");
  property p_reset_held;
    (!s_r.filt[P_RST] && s_r.rst_cnt == RST_CNT_W'(RESET_MIN_CYCLES)) |=>
      (s_r.mode == MODE_HELD && o_data_not_ready);
  endproperty
  a_reset_held: assert property (p_reset_held) else $error("long reset not taken");
  property p_short_pulse;
    (s_r.mode == MODE_RUN && s_r.filt[P_RST]) ##1 (!s_r.filt[P_RST])[*2] ##1 s_r.filt[P_RST]
      |-> s_r.mode == MODE_RUN;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short reset pulse acted");
  property p_done;
    $rose(s_r.flags[F_DONE]) |-> (o_attention_n_oe && !o_data_not_ready && !m.status[0]);
  endproperty
  a_done: assert property (p_done) else $error("completion without ready status");
  property p_init_bound;
    s_r.mode == MODE_INIT |-> s_r.init_cnt <= INIT_CNT_W'(INIT_CYCLES - 1);
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("initialisation overran");
  property p_open_drain;
    !o_attention_n_o && !o_sda_o && (o_attention_n_oe == (s_r.flags != '0));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("attention drive wrong");
  property p_presence;
    o_presence_n_oe && !o_presence_n_o;
  endproperty
  a_presence: assert property (p_presence) else $error("presence not held low");
  property p_transmit_disable;
    (s_r.filt[P_TXD] || m.tx_soft != '0) |=> (o_tx_off & $past(m.tx_soft)) == $past(m.tx_soft)
      && (!$past(s_r.filt[P_TXD]) || o_tx_off == '1);
  endproperty
  a_transmit_disable: assert property (p_transmit_disable) else $error("transmitter not disabled");
  property p_los;
    (s_r.filt[P_LOS +: LANES] != '0) |=> o_receive_signal_lost;
  endproperty
  a_los: assert property (p_los) else $error("signal-lost alarm missing");
  property p_lowpow;
    s_r.filt[P_LP] |=> !o_high_power_en;
  endproperty
  a_lowpow: assert property (p_lowpow) else $error("low power not enforced");
  property p_fault;
    (i_fault && s_r.mode != MODE_HELD && !(!s_r.filt[P_RST] &&
      s_r.rst_cnt == RST_CNT_W'(RESET_MIN_CYCLES))) |=> !o_attention_n_o && o_attention_n_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");

endmodule : optical_module_mgmt

// [hw/optical_mgmt_pkg.sv]
// Shared constants, encodings and state types of the module management logic.
package optical_mgmt_pkg;

  localparam int LANES = 4;
  localparam int MCLK_HZ = 25_000_000;
  localparam int INIT_TIME_MS = 2000;
  // Longest time, rounded down to whole cycles.
  localparam int INIT_CYCLES = INIT_TIME_MS * (MCLK_HZ / 1000);
  localparam int INIT_CNT_W = 26;
  localparam int RESET_MIN_CYCLES = 25;
  localparam int RST_CNT_W = 16;
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // Positions in the synchronised pin vector.
  localparam int PIN_W = 10;
  localparam int P_SCL = 0;
  localparam int P_SDA = 1;
  localparam int P_SEL = 2;
  localparam int P_RST = 3;
  localparam int P_LP = 4;
  localparam int P_TXD = 5;
  localparam int P_LOS = 6;
  localparam logic [PIN_W-1:0] PIN_RESET = 10'h03F;

  // Memory map offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h01;
  localparam logic [7:0] OFF_MON0 = 8'h02;
  localparam logic [7:0] OFF_LOS = 8'h06;
  localparam logic [7:0] OFF_CTRL = 8'h07;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Flag byte layout: bit 0 reset done, bit 1 fault, bits 2..5 lane signal loss.
  localparam int FLAG_W = 6;
  localparam int F_DONE = 0;
  localparam int F_FAULT = 1;
  localparam int F_LOS = 2;

  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_RUN = 2'b01,
    MODE_HELD = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_DEVADDR = 3'b001,
    SER_ACK = 3'b010,
    SER_OFFSET = 3'b011,
    SER_WRITE = 3'b100,
    SER_READ = 3'b101,
    SER_RACK = 3'b110
  } ser_t;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] filt;
    mode_t mode;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic [FLAG_W-1:0] flags;
    ser_t ser;
    ser_t ser_next;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] offset;
    logic drive;
    logic nack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wdata;
    logic lost;
    logic [LANES-1:0] tx_off;
    logic high_power;
  } mgmt_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
  } regs_state_t;

endpackage : optical_mgmt_pkg

// [hw/mmap_if.sv]
// Carrier between the management engine and its memory map store.
`timescale 1ns/1ps
interface mmap_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wdata;
  logic [7:0] rd_addr;
  logic [7:0] rdata;
  logic soft_rst;
  logic [7:0] status;
  logic [7:0] flags;
  logic [31:0] monitor;
  logic [3:0] los;
  logic [3:0] tx_soft;

  modport engine (
    output wr_en, wr_addr, wdata, rd_addr, soft_rst, status, flags, monitor, los,
    input rdata, tx_soft
  );
  modport store (
    input wr_en, wr_addr, wdata, rd_addr, soft_rst, status, flags, monitor, los,
    output rdata, tx_soft
  );
endinterface : mmap_if

// [hw/mmap_regs.sv]
// Memory map store: writable control byte and registered read data.
`timescale 1ns/1ps
module mmap_regs (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // Engine side.
  mmap_if.store m
);
  import optical_mgmt_pkg::*;

  regs_state_t s_r;
  regs_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (m.soft_rst) begin
      s_nxt.ctrl = CTRL_RESET;
    end else if (m.wr_en && m.wr_addr == OFF_CTRL) begin
      s_nxt.ctrl = m.wdata;
    end
    if (m.rd_addr == OFF_STATUS) begin
      s_nxt.rdata = m.status;
    end else if (m.rd_addr == OFF_FLAGS) begin
      s_nxt.rdata = m.flags;
    end else if (m.rd_addr >= OFF_MON0 && m.rd_addr < OFF_LOS) begin
      s_nxt.rdata = m.monitor[8*(m.rd_addr[1:0]^2'h2) +: 8];
    end else if (m.rd_addr == OFF_LOS) begin
      s_nxt.rdata = {4'h0, m.los};
    end else if (m.rd_addr == OFF_CTRL) begin
      s_nxt.rdata = s_r.ctrl;
    end else begin
      s_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign m.rdata = s_r.rdata;
  assign m.tx_soft = s_r.ctrl[3:0];

endmodule : mmap_regs

// [tb/host_model.sv]
// Host board model: two-wire bus master sharing an open-drain data line.
`timescale 1ns/1ps
module host_model (
  // Wire level.
  input wire logic i_sda,
  // Host drives.
  output logic o_scl,
  output logic o_sda_low
);
  import optical_mgmt_pkg::*;
  localparam int QUARTER = 80;
  // Frames start this far after a clock edge, so no pin change meets a sampling edge.
  localparam int SKEW = 10;

  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Serves as first and repeated start; leaves the clock low.
  task automatic start_cond;
    o_sda_low = 1'b0;
    #QUARTER o_scl = 1'b1;
    #QUARTER o_sda_low = 1'b1;
    #QUARTER o_scl = 1'b0;
    #QUARTER;
  endtask : start_cond

  // The clock stands high after a stop, so the link is still between frames.
  task automatic stop_cond;
    o_sda_low = 1'b1;
    #QUARTER o_scl = 1'b1;
    #QUARTER o_sda_low = 1'b0;
    #(2*QUARTER);
  endtask : stop_cond

  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    #QUARTER o_scl = 1'b1;
    #QUARTER r = i_sda;
    #QUARTER o_scl = 1'b0;
    #QUARTER;
  endtask : bit_io

  // A one releases the line, so 8'hFF with ack_in high just listens.
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask : byte_io

  task automatic write_reg(input logic [7:0] off, input logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    #SKEW;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a[0]);
    byte_io(off, 1'b1, q, a[1]);
    byte_io(data, 1'b1, q, a[2]);
    stop_cond();
    ok = (a === 3'b000);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] off, output logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic [2:0] a;
    logic nack;
    #SKEW;
    start_cond();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a[0]);
    byte_io(off, 1'b1, q, a[1]);
    start_cond();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a[2]);
    byte_io(8'hFF, 1'b1, data, nack);
    stop_cond();
    ok = (a === 3'b000);
  endtask : read_reg
endmodule : host_model

// [tb/test_optical_module_mgmt.sv]
// Testbench of the module management pins and memory map access.
`timescale 1ns/1ps
module test_optical_module_mgmt;
  import optical_mgmt_pkg::*;
  logic mclk = 1'b0;
  logic rst, sel_n, rst_pin_n, lp, txd, fault, scl, sda_low, ok;
  // Only this module sits on the bus, so it has the one select line.
  logic [LANES-1:0] lane_low, tx_off;
  logic [31:0] mon;
  logic sda_oe, sda_o, att_oe, att_o, pres_oe, pres_o, lost, hp, not_ready;
  logic sda_w, att_w, pres_w;
  logic [7:0] d;
  int n_errors = 0;
  int check_count = 0;

  always #20 mclk = ~mclk;
  assign sda_w = ~sda_low & (sda_oe ? sda_o : 1'b1);
  assign att_w = att_oe ? att_o : 1'b1;
  assign pres_w = pres_oe ? pres_o : 1'b1;

  optical_module_mgmt #(.INIT_CYCLES(20), .RESET_MIN_CYCLES(4)) u_dut (
    .i_mclk(mclk), .i_rst(rst), .i_module_select_n(sel_n), .i_module_reset_n(rst_pin_n),
    .i_low_power_pin(lp), .i_transmit_disable(txd), .i_scl(scl), .i_sda(sda_w),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_attention_n_o(att_o), .o_attention_n_oe(att_oe),
    .o_presence_n_o(pres_o), .o_presence_n_oe(pres_oe), .o_receive_signal_lost(lost),
    .i_lane_signal_low(lane_low), .i_optical_monitor(mon), .i_fault(fault),
    .o_tx_off(tx_off), .o_high_power_en(hp), .o_data_not_ready(not_ready)
  );

  host_model u_host (.i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_byte

  task automatic wait_ready(input logic want);
    for (int i = 0; i < 200 && not_ready !== want; i++) begin
      @(posedge mclk);
    end
    if (not_ready !== want) begin
      n_errors++;
      $display("BAD %0t ready wait timed out", $time);
      summarize();
    end
  endtask : wait_ready

  task automatic rd(input logic [7:0] off, output logic [7:0] q);
    @(posedge mclk);
    u_host.read_reg(off, q, ok);
    check_bit(ok, 1'b1, "read acked");
  endtask : rd

  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask : settle

  task automatic t_powerup;
    check_bit(not_ready, 1'b1, "not ready in init");
    check_bit(att_w, 1'b1, "attention idle in init");
    check_bit(pres_w, 1'b0, "presence low");
    wait_ready(1'b0);
    repeat (2) @(posedge mclk);
    check_bit(att_w, 1'b0, "completion attention");
    check_bit(att_o, 1'b0, "never driven high");
    rd(OFF_STATUS, d);
    check_byte(d, 8'h00, "status after init");
    rd(OFF_FLAGS, d);
    check_byte(d, 8'h01, "done flag");
    settle();
    check_bit(att_w, 1'b1, "attention cleared");
  endtask : t_powerup

  task automatic t_select;
    sel_n <= 1'b1;
    settle();
    u_host.write_reg(OFF_CTRL, 8'h05, ok);
    check_bit(ok, 1'b0, "ack while deselected");
    check_byte({4'h0, tx_off}, 8'h00, "ignored write");
    sel_n <= 1'b0;
    settle();
    u_host.write_reg(OFF_CTRL, 8'h05, ok);
    check_bit(ok, 1'b1, "write acked");
    settle();
    check_byte({4'h0, tx_off}, 8'h05, "serial disable");
    txd <= 1'b1;
    settle();
    check_byte({4'h0, tx_off}, 8'h0F, "pin disable");
    txd <= 1'b0;
    settle();
    check_byte({4'h0, tx_off}, 8'h05, "pin released");
    rd(OFF_CTRL, d);
    check_byte(d, 8'h05, "control readback");
  endtask : t_select

  task automatic t_loss;
    lane_low <= 4'b0100;
    settle();
    check_bit(lost, 1'b1, "loss alarm");
    check_bit(att_w, 1'b0, "attention on loss");
    rd(OFF_LOS, d);
    check_byte(d, 8'h04, "live loss");
    rd(OFF_FLAGS, d);
    check_byte(d, 8'h10, "loss event");
    lane_low <= 4'b0000;
    fault <= 1'b1;
    @(posedge mclk);
    fault <= 1'b0;
    settle();
    check_bit(lost, 1'b0, "loss alarm off");
    rd(OFF_FLAGS, d);
    check_byte(d, 8'h02, "fault flag");
    settle();
    check_bit(att_w, 1'b1, "attention released");
  endtask : t_loss

  task automatic t_monitor;
    logic [31:0] pattern;
    pattern = 32'hC3A55A3C;
    mon <= pattern;
    settle();
    for (int n = 0; n < LANES; n++) begin
      rd(OFF_MON0 + 8'(n), d);
      check_byte(d, pattern[8*n +: 8], "lane monitor");
    end
  endtask : t_monitor

  task automatic t_power;
    lp <= 1'b1;
    settle();
    check_bit(hp, 1'b0, "low power limit");
    lp <= 1'b0;
    settle();
    check_bit(hp, 1'b1, "full power allowed");
  endtask : t_power

  task automatic t_reset_pin;
    rst_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_pin_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check_bit(not_ready, 1'b0, "short pulse ignored");
    check_byte({4'h0, tx_off}, 8'h05, "settings kept");
    rst_pin_n <= 1'b0;
    repeat (12) @(posedge mclk);
    check_bit(not_ready, 1'b1, "held in reset");
    rst_pin_n <= 1'b1;
    wait_ready(1'b0);
    repeat (2) @(posedge mclk);
    check_bit(att_w, 1'b0, "reset completion");
    rd(OFF_CTRL, d);
    check_byte(d, 8'h00, "control default");
    check_byte({4'h0, tx_off}, 8'h00, "lanes back on");
    rd(OFF_STATUS, d);
    check_byte(d, 8'h00, "status after reset");
    rd(OFF_FLAGS, d);
    check_byte(d, 8'h01, "done flag again");
  endtask : t_reset_pin

  initial begin
    rst = 1'b1;
    sel_n = 1'b0;
    rst_pin_n = 1'b1;
    lp = 1'b0;
    txd = 1'b0;
    fault = 1'b0;
    lane_low = 4'h0;
    mon = 32'h00000000;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_powerup();
    t_select();
    t_loss();
    t_monitor();
    t_power();
    t_reset_pin();
    summarize();
  end
endmodule : test_optical_module_mgmt
